// [src/pbk_blank_if.sv]
// interface: one blanking timer's control and state
`timescale 1ns/1ps
`default_nettype none
interface pbk_blank_if;
	logic [1:0] mode;
	logic [7:0] length;
	logic edge_seen;
	logic active;
	modport owner (output mode, output length, output edge_seen, input active);
	modport timer (input mode, input length, input edge_seen, output active);
endinterface
`default_nettype wire

// [src/pbk_blank_timer.sv]
// module: one blanking interval timer
`timescale 1ns/1ps
`default_nettype none
module pbk_blank_timer
	import pbk_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control from the owner
	pbk_blank_if.timer bl
);
	pbk_blank_e state_r;
	logic [7:0] cnt_r;

	// interval opens at the output edge and counts module clocks
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= PBK_IDLE;
			cnt_r <= 8'h00;
		end else begin
			case (state_r)
				PBK_IDLE: begin
					// reserved modes behave as no blanking
					if (bl.edge_seen && bl.mode == BM_IMMEDIATE && bl.length != 8'h00) begin // see [RULE10]
						state_r <= PBK_BLANK;
						cnt_r <= bl.length - 8'h01;
					end
				end
				PBK_BLANK: begin
					// a fresh edge restarts the interval
					// a zero length must not wrap the count into a long interval
					if (bl.edge_seen && bl.mode == BM_IMMEDIATE && bl.length != 8'h00) begin
						cnt_r <= bl.length - 8'h01;
					end else if (cnt_r == 8'h00 || bl.mode != BM_IMMEDIATE) begin
						state_r <= PBK_IDLE; // see [RULE10]
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				default: state_r <= PBK_IDLE;
			endcase
		end
	end

	assign bl.active = (state_r == PBK_BLANK);
endmodule
`default_nettype wire

// [src/pbk_pkg.sv]
// package: register map, field positions and reset values of the polarity/blanking stage
// How it works
// [RULE1] input polarity bit set means pin active-low
// [RULE2] output polarity bits five..zero invert their outputs
// [RULE3] second instance keeps only outputs A and B
// [RULE4] falling blank mode: 00 none, 01 immediate
// [RULE5] rising blank mode: 00 none, 01 immediate
// [RULE6] rising blank masks selected sources during interval
// [RULE7] falling blank masks selected sources during interval
// [RULE8] unused register bits read zero, ignore writes; the unused phase select bit 0 is stored and reads back
// [RULE9] all implemented bits clear on any reset
// [RULE10] blank starts at output edge, lasts programmed cycles
// [RULE11] input polarity before blanking, output polarity last
package pbk_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_POL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_BLNK = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_REBS = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_FEBS = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_PHS = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_RBTIME = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_FBTIME = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h7;
	localparam int unsigned NUM_OUT = 6;
	localparam int unsigned POL_IN_BIT = 6;
	localparam logic [7:0] POL_MASK_FULL = 8'h7f;
	localparam logic [7:0] POL_MASK_LITE = 8'h43;
	localparam logic [7:0] BLNK_MASK = 8'h33;
	localparam int unsigned FEBM_LSB = 4;
	localparam int unsigned REBM_LSB = 0;
	localparam logic [7:0] SRC_MASK = 8'h8e;
	localparam logic [7:0] PHS_MASK = 8'h8f;
	localparam int unsigned SRC_PIN_BIT = 7;
	localparam logic [1:0] BM_NONE = 2'h0;
	localparam logic [1:0] BM_IMMEDIATE = 2'h1;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] BTIME_RESET = 8'h00;
	typedef enum logic {PBK_IDLE, PBK_BLANK} pbk_blank_e;
endpackage

// [src/pbk_top.sv]
// module: polarity and edge-blanking stage with wishbone registers
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pbk_top
	import pbk_pkg::*;
#(
	parameter bit SECOND_INSTANCE = 1'b0
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W+1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// external sources
	input wire logic modulation_input_pin_i,
	input wire logic [3:1] cmp_i,
	// internal waveform, active-high
	input wire logic [NUM_OUT-1:0] pwm_raw_i,
	// conditioned sources and events
	output logic pin_active_o,
	output logic [3:1] cmp_gated_o,
	output logic pin_gated_o,
	output logic rise_event_o,
	output logic blank_rise_o,
	output logic blank_fall_o,
	// output pins
	output logic [NUM_OUT-1:0] pwm_o
);
	// effective writable masks: the lite instance has only outputs A and B
	localparam logic [7:0] POL_MASK = SECOND_INSTANCE ? POL_MASK_LITE : POL_MASK_FULL;

	logic [7:0] polarity_control_r;
	logic [7:0] blanking_mode_control_r;
	logic [7:0] rising_blank_source_select_r;
	logic [7:0] falling_blank_source_select_r;
	logic [7:0] phase_event_source_select_r;
	logic [7:0] rise_len_r;
	logic [7:0] fall_len_r;
	logic [2:0] pin_sync_r;
	logic [2:0] cmp_sync_r [3:1];
	logic pin_stable_r;
	logic [3:1] cmp_stable_r;
	logic [NUM_OUT-1:0] raw_d_r;
	logic pin_g_d_r;
	logic [3:1] cmp_g_d_r;
	logic [NUM_OUT-1:0] pwm_r;
	logic rise_evt_r;
	logic ack_r;
	logic err_r;
	logic [31:0] rdata_r;
	logic req;
	logic wr_en;
	logic [ADDR_W-1:0] idx;
	logic hit;
	logic [7:0] wbyte;
	logic [7:0] rd_val;
	logic pin_pol;
	logic [3:0] src_mask;
	logic [3:0] src_in;
	logic [3:0] src_gated;
	logic any_rise;
	logic any_fall;

	pbk_blank_if rise_bl ();
	pbk_blank_if fall_bl ();

	// bus request decode; ack is withheld the cycle after an answer
	assign req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
	assign idx = wb_adr_i[ADDR_W+1:2];
	assign wbyte = wb_dat_i[7:0];
	assign wr_en = req && wb_we_i && hit && wb_sel_i[0];

	// address decode
	always_comb begin
		hit = 1'b1;
		rd_val = 8'h00;
		if (idx == OFS_POL) begin
			rd_val = polarity_control_r;
		end else if (idx == OFS_BLNK) begin
			rd_val = blanking_mode_control_r;
		end else if (idx == OFS_REBS) begin
			rd_val = rising_blank_source_select_r;
		end else if (idx == OFS_FEBS) begin
			rd_val = falling_blank_source_select_r;
		end else if (idx == OFS_PHS) begin
			rd_val = phase_event_source_select_r;
		end else if (idx == OFS_RBTIME) begin
			rd_val = rise_len_r;
		end else if (idx == OFS_FBTIME) begin
			rd_val = fall_len_r;
		end else if (idx == OFS_STATUS) begin
			rd_val = {5'h00, pin_stable_r, rise_bl.active, fall_bl.active};
		end else begin
			hit = 1'b0;
		end
	end

	// bus answer: one cycle after the request, unmapped gives err
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			err_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= req && hit;
			err_r <= req && !hit;
			if (req && hit && !wb_we_i) begin
				rdata_r <= {24'h00_0000, rd_val};
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_err_o = err_r;
	assign wb_dat_o = rdata_r;

	// configuration registers; masks keep unused bits at zero, except phase select bit 0, which PHS_MASK keeps writable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			polarity_control_r <= REG_RESET; // see [RULE9]
			blanking_mode_control_r <= REG_RESET; // see [RULE9]
			rising_blank_source_select_r <= REG_RESET; // see [RULE9]
			falling_blank_source_select_r <= REG_RESET; // see [RULE9]
			phase_event_source_select_r <= REG_RESET; // see [RULE9]
			rise_len_r <= BTIME_RESET;
			fall_len_r <= BTIME_RESET;
		end else if (wr_en) begin
			if (idx == OFS_POL) begin
				polarity_control_r <= wbyte & POL_MASK; // see [RULE8] see [RULE3]
			end else if (idx == OFS_BLNK) begin
				blanking_mode_control_r <= wbyte & BLNK_MASK; // see [RULE8]
			end else if (idx == OFS_REBS) begin
				rising_blank_source_select_r <= wbyte & SRC_MASK; // see [RULE8]
			end else if (idx == OFS_FEBS) begin
				falling_blank_source_select_r <= wbyte & SRC_MASK; // see [RULE8]
			end else if (idx == OFS_PHS) begin
				phase_event_source_select_r <= wbyte & PHS_MASK;
			end else if (idx == OFS_RBTIME) begin
				rise_len_r <= wbyte;
			end else if (idx == OFS_FBTIME) begin
				fall_len_r <= wbyte;
			end
		end
	end

	// pin and comparators are asynchronous: three stages, change once last two agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_sync_r <= 3'h0;
			pin_stable_r <= 1'b0;
		end else begin
			pin_sync_r <= {pin_sync_r[1:0], modulation_input_pin_i};
			if (pin_sync_r[1] == pin_sync_r[2]) begin
				pin_stable_r <= pin_sync_r[2];
			end
		end
	end

	genvar c;
	generate
		for (c = 1; c <= 3; c++) begin : g_cmp
			// one synchroniser per comparator
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					cmp_sync_r[c] <= 3'h0;
					cmp_stable_r[c] <= 1'b0;
				end else begin
					cmp_sync_r[c] <= {cmp_sync_r[c][1:0], cmp_i[c]};
					if (cmp_sync_r[c][1] == cmp_sync_r[c][2]) begin
						cmp_stable_r[c] <= cmp_sync_r[c][2];
					end
				end
			end
		end
	endgenerate

	// input polarity applied before blanking, so masks see the true level
	assign pin_pol = polarity_control_r[POL_IN_BIT] ? ~pin_stable_r : pin_stable_r; // see [RULE1] see [RULE11]
	assign src_in = {pin_pol, cmp_stable_r};

	// blanking masks: bit 3 is the pin, bits 2..0 comparators 3..1
	always_comb begin
		src_mask = 4'h0;
		if (rise_bl.active) begin // see [RULE6]
			src_mask = src_mask | {rising_blank_source_select_r[SRC_PIN_BIT],
				rising_blank_source_select_r[3:1]};
		end
		if (fall_bl.active) begin // see [RULE7]
			src_mask = src_mask | {falling_blank_source_select_r[SRC_PIN_BIT],
				falling_blank_source_select_r[3:1]};
		end
	end

	assign src_gated = src_in & ~src_mask;
	assign pin_active_o = pin_pol;
	assign pin_gated_o = src_gated[3];
	assign cmp_gated_o = src_gated[2:0];

	// phase sources: a gated source selected in phase_event_source_select_r going true raises a rising event
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_g_d_r <= 1'b0;
			cmp_g_d_r <= 3'h0;
			rise_evt_r <= 1'b0;
		end else begin
			pin_g_d_r <= src_gated[3];
			cmp_g_d_r <= src_gated[2:0];
			rise_evt_r <= (phase_event_source_select_r[SRC_PIN_BIT] && src_gated[3] && !pin_g_d_r)
				|| (|(phase_event_source_select_r[3:1] & src_gated[2:0] & ~cmp_g_d_r));
		end
	end

	assign rise_event_o = rise_evt_r;

	// waveform edges are seen on the internal active-high signal, not the pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			raw_d_r <= '0;
		end else begin
			raw_d_r <= pwm_raw_i;
		end
	end

	assign any_rise = |(pwm_raw_i & ~raw_d_r);
	assign any_fall = |(~pwm_raw_i & raw_d_r);

	// blanking timers driven by the mode fields
	assign rise_bl.mode = blanking_mode_control_r[REBM_LSB +: 2]; // see [RULE5]
	assign rise_bl.length = rise_len_r;
	assign rise_bl.edge_seen = any_rise; // see [RULE10]
	assign fall_bl.mode = blanking_mode_control_r[FEBM_LSB +: 2]; // see [RULE4]
	assign fall_bl.length = fall_len_r;
	assign fall_bl.edge_seen = any_fall; // see [RULE10]

	pbk_blank_timer u_rise_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.bl(rise_bl.timer)
	);

	pbk_blank_timer u_fall_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.bl(fall_bl.timer)
	);

	assign blank_rise_o = rise_bl.active;
	assign blank_fall_o = fall_bl.active;

	// output polarity last, so it never shifts internal event timing
	genvar o;
	generate
		for (o = 0; o < NUM_OUT; o++) begin : g_out
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pwm_r[o] <= 1'b0;
				end else if (POL_MASK[o]) begin
					pwm_r[o] <= pwm_raw_i[o] ^ polarity_control_r[o]; // see [RULE2] see [RULE11]
				end else begin
					pwm_r[o] <= 1'b0; // absent outputs on the lite instance, see [RULE3]
				end
			end
		end
	endgenerate

	assign pwm_o = pwm_r;
endmodule
`default_nettype wire

// [testbench/pbk_partner.sv]
// partner: pin and comparator feedback with a settling lag
`timescale 1ns/1ps
`default_nettype none
module pbk_partner (
	// clock and commanded levels, pin on top
	input wire logic clk_i,
	input wire logic [3:0] lvl_i,
	// feedback driven into the stage
	output logic pin_o,
	output logic [3:1] cmp_o
);
	logic [3:0] near_r, far_r;
	// comparators settle two cycles after the analog level moves
	always_ff @(posedge clk_i) begin
		near_r <= lvl_i;
		far_r <= near_r;
	end
	assign {pin_o, cmp_o} = far_r;
endmodule
`default_nettype wire

// [testbench/pbk_sva.sv]
// checker: bus, polarity and blanking properties of the stage
`timescale 1ns/1ps
`default_nettype none
module pbk_sva
	import pbk_pkg::*;
#(
	parameter bit SECOND_INSTANCE = 1'b0
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W+1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	// sources and outputs
	input wire logic [NUM_OUT-1:0] pwm_raw_i,
	input wire logic pin_active_o,
	input wire logic [3:1] cmp_gated_o,
	input wire logic pin_gated_o,
	input wire logic blank_rise_o,
	input wire logic blank_fall_o,
	input wire logic [NUM_OUT-1:0] pwm_o
);
	logic take;
	logic [7:0] cfg_r [7];
	logic [5:0] keep;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign keep = SECOND_INSTANCE ? 6'h03 : 6'h3f;
	// shadow of written settings; only implemented fields are looked at
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_r <= '{default: 8'h00};
		end else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i[5:2] < 4'h7) begin
			cfg_r[wb_adr_i[5:2]] <= wb_dat_i[7:0];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_quiet; pwm_raw_i == $past(pwm_raw_i); endsequence
	sequence s_redge; |(pwm_raw_i & ~$past(pwm_raw_i)) && cfg_r[1][1:0] == 2'h1; endsequence
	sequence s_fedge; |(~pwm_raw_i & $past(pwm_raw_i)) && cfg_r[1][5:4] == 2'h1; endsequence
	property p_ack; take |=> wb_ack_o != wb_err_o; endproperty
	a_ack: assert property (p_ack) else $error("request not answered once");
	property p_err; take && wb_adr_i[5:2] > 4'h7 |=> wb_err_o; endproperty
	a_err: assert property (p_err) else $error("unmapped index not refused");
	property p_pwm;
		!$past(rst_i) && $stable(cfg_r[0]) |-> pwm_o == (($past(pwm_raw_i) ^ cfg_r[0][5:0]) & keep);
	endproperty
	a_pwm: assert property (p_pwm) else $error("output polarity wrong");
	property p_rstart; (s_redge and cfg_r[5] != 8'h00) |=> blank_rise_o; endproperty
	a_rstart: assert property (p_rstart) else $error("rising blank not started");
	property p_rend;
		(s_redge and cfg_r[5] == 8'h03) ##1 s_quiet [*3] |=> !blank_rise_o;
	endproperty
	a_rend: assert property (p_rend) else $error("rising blank length wrong");
	property p_fstart; (s_fedge and cfg_r[6] != 8'h00) |=> blank_fall_o; endproperty
	a_fstart: assert property (p_fstart) else $error("falling blank not started");
	property p_rmask;
		blank_rise_o |-> !(pin_gated_o && cfg_r[2][7]) && (cmp_gated_o & cfg_r[2][3:1]) == 3'h0;
	endproperty
	a_rmask: assert property (p_rmask) else $error("source passed rising blank");
	property p_fmask;
		blank_fall_o |-> !(pin_gated_o && cfg_r[3][7]) && (cmp_gated_o & cfg_r[3][3:1]) == 3'h0;
	endproperty
	a_fmask: assert property (p_fmask) else $error("source passed falling blank");
	property p_pass; !blank_rise_o && !blank_fall_o |-> pin_gated_o == pin_active_o; endproperty
	a_pass: assert property (p_pass) else $error("pin gated outside blanking");
	property p_rst;
		$fell(rst_i) |-> !wb_ack_o && pwm_o == 6'h00 && !blank_rise_o && !blank_fall_o;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind pbk_top pbk_sva #(.SECOND_INSTANCE(SECOND_INSTANCE)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.pwm_raw_i(pwm_raw_i), .pin_active_o(pin_active_o), .cmp_gated_o(cmp_gated_o),
	.pin_gated_o(pin_gated_o), .blank_rise_o(blank_rise_o), .blank_fall_o(blank_fall_o),
	.pwm_o(pwm_o));
`default_nettype wire

// [testbench/pbk_top_tb_top.sv]
// testbench: registers, polarity and blanking of the stage
`timescale 1ns/1ps
`default_nettype none
module pbk_top_tb_top;
	import pbk_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [5:0] raw = 6'h00;
	logic [3:0] sel = 4'h0;
	logic [3:0] lvl = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, v;
	logic ack, err, pin, pin_act, pin_g, br, bf, rev;
	logic [3:1] cmp, cmp_g;
	logic [5:0] pwm, pwm2;
	logic [32:0] exp_q [$];
	logic [7:0] mask [7] = '{POL_MASK_FULL, BLNK_MASK, SRC_MASK, SRC_MASK, PHS_MASK, 8'hff, 8'hff};
	int seed = 32'h1702;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;
	pbk_partner sw (.clk_i(clk_i), .lvl_i(lvl), .pin_o(pin), .cmp_o(cmp));
	pbk_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.wb_err_o(err), .modulation_input_pin_i(pin), .cmp_i(cmp), .pwm_raw_i(raw),
		.pin_active_o(pin_act), .cmp_gated_o(cmp_g), .pin_gated_o(pin_g), .rise_event_o(rev),
		.blank_rise_o(br), .blank_fall_o(bf), .pwm_o(pwm));
	// lite instance shares the stimulus; only its outputs A and B may follow the waveform
	pbk_top #(.SECOND_INSTANCE(1'b1)) uut_lite (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(), .wb_ack_o(), .wb_err_o(), .modulation_input_pin_i(pin), .cmp_i(cmp),
		.pwm_raw_i(raw), .pin_active_o(), .cmp_gated_o(), .pin_gated_o(), .rise_event_o(),
		.blank_rise_o(), .blank_fall_o(), .pwm_o(pwm2));
	task automatic chk(input logic [32:0] seen, input logic [32:0] want);
		comparisons++;
		if (seen !== want) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic conclude;
		if (num_errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// one classic cycle; the monitor compares the answer with the note left here
	task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d,
		input logic [3:0] s, input logic [32:0] want);
		exp_q.push_back(want);
		cyc <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= s;
		wdat <= {24'h0, d};
		do @(posedge clk_i); while (!(ack || err));
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic read_all(input logic full);
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, 4'(i), 8'h00, 4'h1, {25'h0, full ? mask[i] : 8'h00});
		end
	endtask
	// count cycles of one blanking flag, checking that masked sources stay low
	task automatic watch(input logic rise, input int want);
		n = 0;
		repeat (8) begin
			@(negedge clk_i);
			if (rise ? br : bf) begin
				n++;
				chk({pin_g, cmp_g}, 4'h0);
			end
		end
		chk(33'(n), 33'(want));
		@(posedge clk_i);
	endtask
	// phase source: only a selected pin going true may give one event pulse
	task automatic events(input logic [7:0] phs, input int want);
		bus(1'b1, 4'h4, phs, 4'h1, 33'h0);
		lvl <= 4'h0;
		repeat (12) @(posedge clk_i);
		lvl <= 4'hf;
		n = 0;
		repeat (16) begin
			@(negedge clk_i);
			if (rev === 1'b1) begin
				n++;
			end
		end
		chk(33'(n), 33'(want));
		@(posedge clk_i);
	endtask
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	// hang guard: the run needs a few thousand cycles at most
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 20000) begin
			num_errors++;
			conclude();
		end
	end
	// bus answers against the oldest note; read data ignored on writes and refusals
	always @(posedge clk_i) begin
		if (ack || err) begin
			chk({err, (we || err) ? 32'h0 : rdat}, exp_q.pop_front());
		end
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		read_all(1'b0);
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, 4'(i), 8'hff, 4'h1, 33'h0);
		end
		read_all(1'b1);
		// a write without the low lane enable must leave the register alone
		bus(1'b1, 4'h0, 8'h00, 4'h0, 33'h0);
		bus(1'b0, 4'h0, 8'h00, 4'h1, {25'h0, POL_MASK_FULL});
		bus(1'b1, 4'hc, 8'h00, 4'h1, {1'b1, 32'h0});
		bus(1'b0, 4'h8, 8'h00, 4'h1, {1'b1, 32'h0});
		// input polarity set: a low pin level counts as active
		repeat (8) @(posedge clk_i);
		chk(pin_act, 1'b1);
		bus(1'b1, 4'h0, 8'h00, 4'h1, 33'h0);
		repeat (4) @(posedge clk_i);
		chk(pin_act, 1'b0);
		lvl <= 4'hf;
		for (int i = 0; i < 8; i++) begin
			v = $random(seed);
			bus(1'b1, 4'h0, v[7:0], 4'h1, 33'h0);
			raw <= v[13:8];
			repeat (2) @(posedge clk_i);
			chk(pwm, v[13:8] ^ v[5:0]);
			chk(pwm2, (v[13:8] ^ v[5:0]) & 6'h03);
		end
		bus(1'b1, 4'h0, 8'h00, 4'h1, 33'h0);
		bus(1'b1, 4'h5, 8'h03, 4'h1, 33'h0);
		bus(1'b1, 4'h6, 8'h03, 4'h1, 33'h0);
		raw <= 6'h00;
		repeat (300) @(posedge clk_i);
		chk({pin_act, pin_g, cmp_g}, 5'h1f);
		// status: settled pin high, no interval running, upper bits zero
		bus(1'b0, 4'h7, 8'h00, 4'h1, {25'h0, 8'h04});
		events(8'h00, 0);
		events(8'h80, 1);
		// every mode code; only immediate blanking may mask the sources
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, 4'h1, {2'h0, 2'(m), 2'h0, 2'(m)}, 4'h1, 33'h0);
			raw <= 6'h21;
			watch(1'b1, m == 1 ? 3 : 0);
			raw <= 6'h00;
			watch(1'b0, m == 1 ? 3 : 0);
		end
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		read_all(1'b0);
		conclude();
	end
endmodule
`default_nettype wire
